//--- logic/otwd_pkg.sv
// Purpose: Shared constants and types for the one-time enabled watchdog
// Assumes: Registers reached over classic Wishbone, byte data in low bits
// Notes: Service register index 0xa6 is not a multiple of four, so byte address is four times it
package otwd_pkg;
  localparam logic [7:0] OTWD_SERVICE_IDX = 8'ha6;
  localparam logic [9:0] OTWD_SERVICE_ADDR = {OTWD_SERVICE_IDX, 2'b00};
  localparam logic [7:0] OTWD_CTRL_IDX = 8'ha7;
  localparam logic [9:0] OTWD_CTRL_ADDR = {OTWD_CTRL_IDX, 2'b00};
  localparam logic [7:0] OTWD_KEY_FIRST = 8'h1e;
  localparam logic [7:0] OTWD_KEY_SECOND = 8'he1;
  localparam int OTWD_CNT_W = 14;
  localparam logic [13:0] OTWD_CNT_RESET = 14'h0000;
  localparam logic [13:0] OTWD_CNT_TOP = 14'h3fff;
  localparam int OTWD_CTRL_X2_BIT = 0;
  localparam int OTWD_STAT_ARMED_BIT = 1;
  localparam int OTWD_PULSE_6CLK = 98;
  localparam int OTWD_PULSE_12CLK = 196;
  localparam logic [7:0] OTWD_PULSE_6CLK_CYC = 8'(OTWD_PULSE_6CLK);
  localparam logic [7:0] OTWD_PULSE_12CLK_CYC = 8'(OTWD_PULSE_12CLK);
  localparam logic [3:0] OTWD_MC_6CLK = 4'h5;
  localparam logic [3:0] OTWD_MC_12CLK = 4'hb;

  typedef enum logic [1:0] {OTWD_IDLE, OTWD_GOT_FIRST} otwd_seq_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } otwd_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } otwd_wb_rsp_type;
endpackage

//--- logic/otwd_watchdog.sv
// Purpose: One-time enabled cycle watchdog with reset-out pulse
// Assumes: clk_i is the oscillator, 250 MHz; one oscillator period is one clock
// Notes: Machine cycle is 6 or 12 oscillator periods, chosen by a control bit
//
// What this block does
// RQ1: Fourteen-bit counter counts toward overflow when armed
// RQ2: Comes up disarmed after any reset
// RQ3: Writing 0x1e then 0xe1 arms it
// RQ4: Counts machine cycles; holds when oscillator stops
// RQ5: No software way to disarm once armed
// RQ6: Key pair while armed restarts counter
// RQ7: Overflow at 0x3fff resets whole device; this block clears armed, count and key state but keeps the mode bit
// RQ8: Software services within 16383 machine cycles
// RQ9: Overflow drives reset pin high outward
// RQ10: Pulse 98 or 196 oscillator periods
// RQ11: Service register is write-only
// RQ12: Counter neither readable nor writable
// RQ13: Wrong byte abandons partial key sequence
`timescale 1ns/1ns
`default_nettype none
module otwd_watchdog (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire otwd_pkg::otwd_wb_req_type wb_req_i,
  output var otwd_pkg::otwd_wb_rsp_type wb_rsp_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic armed_o
);
  import otwd_pkg::*;

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  function automatic logic hit(input logic [11:0] adr, input logic [9:0] target);
    hit = (adr[11:2] == target[9:2]);
  endfunction

  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic req;
  logic wr_svc;
  logic wr_ctrl;
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack;
  assign wr_svc = req & wb_req_i.we & wb_req_i.sel[0] & hit(wb_req_i.adr, OTWD_SERVICE_ADDR);
  assign wr_ctrl = req & wb_req_i.we & wb_req_i.sel[0] & hit(wb_req_i.adr, OTWD_CTRL_ADDR);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  otwd_seq_type seq, next_seq;
  logic armed, next_armed;
  logic x2, next_x2;
  logic [OTWD_CNT_W-1:0] cnt, next_cnt;
  logic [3:0] mc, next_mc;
  logic [7:0] pulse, next_pulse;
  logic rst_out, next_rst_out;
  logic key_done;
  logic overflow;

  always_comb begin
    next_ack = req;
    next_rdat = 32'h0000_0000;
    // Service register reads as zero; counter never exposed
    if (req && !wb_req_i.we && hit(wb_req_i.adr, OTWD_CTRL_ADDR)) begin // RQ11 RQ12
      next_rdat[OTWD_CTRL_X2_BIT] = x2;
      next_rdat[OTWD_STAT_ARMED_BIT] = armed;
    end
  end

  always_comb begin
    next_seq = seq;
    key_done = 1'b0;
    if (wr_svc) begin
      case (seq)
        OTWD_IDLE: begin
          if (wb_req_i.dat[7:0] == OTWD_KEY_FIRST) begin
            next_seq = OTWD_GOT_FIRST;
          end
        end
        OTWD_GOT_FIRST: begin
          // Any byte other than 0x1e or 0xe1 drops the half-done sequence; 0x1e keeps it
          if (wb_req_i.dat[7:0] == OTWD_KEY_SECOND) begin // RQ3 RQ6
            key_done = 1'b1;
            next_seq = OTWD_IDLE;
          end else if (wb_req_i.dat[7:0] == OTWD_KEY_FIRST) begin
            next_seq = OTWD_GOT_FIRST;
          end else begin
            next_seq = OTWD_IDLE; // RQ13
          end
        end
        default: begin
          next_seq = OTWD_IDLE;
        end
      endcase
    end
    // Own reset also drops a half-done key pair
    if (overflow) begin
      next_seq = OTWD_IDLE;
    end
  end

  assign overflow = armed && (cnt == OTWD_CNT_TOP);

  // --------------------------------------------------------------
  // Bus response and key sequence registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else if (ce_i) begin
      // Clock enable low models a stopped oscillator
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq <= OTWD_IDLE;
    end else if (ce_i) begin
      seq <= next_seq;
    end
  end

  // --------------------------------------------------------------
  // Clock mode control
  // --------------------------------------------------------------
  always_comb begin
    next_x2 = x2;
    if (wr_ctrl) begin
      next_x2 = wb_req_i.dat[OTWD_CTRL_X2_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x2 <= 1'b0;
    end else if (ce_i) begin
      x2 <= next_x2;
    end
  end

  // --------------------------------------------------------------
  // Arming and cycle counter
  // --------------------------------------------------------------
  always_comb begin
    next_armed = armed;
    next_cnt = cnt;
    next_mc = mc;
    if (key_done) begin
      next_armed = 1'b1; // RQ3 RQ5
    end
    if (armed) begin
      if (mc == 4'h0) begin
        next_mc = x2 ? OTWD_MC_6CLK : OTWD_MC_12CLK;
        next_cnt = cnt + 14'h0001; // RQ1 RQ4
      end else begin
        next_mc = mc - 4'h1;
      end
    end
    // Key pair wins over a count step in the same cycle
    if (key_done) begin
      next_cnt = OTWD_CNT_RESET; // RQ6
      next_mc = x2 ? OTWD_MC_6CLK : OTWD_MC_12CLK;
    end
    if (overflow) begin
      // Own reset clears the watchdog only, not the mode bit
      next_armed = 1'b0; // RQ7
      next_cnt = OTWD_CNT_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed <= 1'b0; // RQ2
      cnt <= OTWD_CNT_RESET;
      mc <= OTWD_MC_12CLK;
    end else if (ce_i) begin
      armed <= next_armed;
      cnt <= next_cnt;
      mc <= next_mc;
    end
  end

  // --------------------------------------------------------------
  // Reset-out pulse
  // --------------------------------------------------------------
  always_comb begin
    next_pulse = pulse;
    next_rst_out = rst_out;
    if (overflow) begin
      // Count ends on zero, so the load is the length less one
      next_rst_out = 1'b1; // RQ9
      next_pulse = (x2 ? OTWD_PULSE_6CLK_CYC : OTWD_PULSE_12CLK_CYC) - 8'h01; // RQ10
    end else if (rst_out) begin
      if (pulse == 8'h00) begin
        next_rst_out = 1'b0;
      end else begin
        next_pulse = pulse - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse <= 8'h00;
      rst_out <= 1'b0;
    end else if (ce_i) begin
      pulse <= next_pulse;
      rst_out <= next_rst_out;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign wb_rsp_o.ack = ack;
  assign wb_rsp_o.dat = rdat;
  assign rst_pin_o = rst_out;
  assign rst_pin_oe_o = rst_out;
  assign armed_o = armed;

  // --------------------------------------------------------------
  // Check helpers
  // --------------------------------------------------------------
  // Enabled clocks since the last count step
  logic [4:0] gap, next_gap;

  always_comb begin
    next_gap = gap;
    if (!armed || key_done || overflow || mc == 4'h0) begin
      next_gap = 5'h00;
    end else begin
      next_gap = gap + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap <= 5'h00;
    end else if (ce_i) begin
      gap <= next_gap;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  never_disarm_a: assert property (ce_i && armed && !overflow |=> armed) else $error("watchdog disarmed"); // RQ5
  arm_seq_a: assert property (ce_i && key_done && !overflow |=> armed && cnt == OTWD_CNT_RESET) else $error("arm failed"); // RQ3
  restart_cnt_a: assert property (ce_i && armed && key_done && !overflow |=> cnt == 14'h0000) else $error("no restart"); // RQ6
  ovf_pulse_a: assert property (ce_i && overflow |=> rst_pin_o && rst_pin_oe_o && !armed) else $error("no pulse"); // RQ7
  pin_drive_a: assert property (ce_i && rst_out && pulse != 8'h00 |=> rst_pin_o && rst_pin_oe_o) else $error("pin dropped"); // RQ9
  pulse_start_a: assert property (ce_i && overflow && x2 |=> pulse == 8'h61) else $error("bad 6clk length"); // RQ10
  pulse_long_a: assert property (ce_i && overflow && !x2 |=> pulse == 8'hc3) else $error("bad 12clk length"); // RQ10
  hold_stop_a: assert property (!ce_i |=> $stable(cnt) && $stable(armed)) else $error("moved while stopped"); // RQ4
  idle_still_a: assert property (!armed && !key_done |=> cnt == 14'h0000) else $error("counted disarmed"); // RQ2
  bad_byte_a: assert property (ce_i && wr_svc && seq == OTWD_GOT_FIRST && wb_req_i.dat[7:0] != OTWD_KEY_SECOND
    && wb_req_i.dat[7:0] != OTWD_KEY_FIRST && !overflow |=> seq == OTWD_IDLE) else $error("bad byte kept"); // RQ13
  svc_read_a: assert property (ce_i && req && !wb_req_i.we && hit(wb_req_i.adr, OTWD_SERVICE_ADDR)
    |=> wb_rsp_o.dat == 32'h0) else $error("service readable"); // RQ11
  cnt_step_a: assert property (ce_i && armed && !key_done && !overflow && mc == 4'h0 |=> cnt == $past(cnt) + 14'h1)
    else $error("count step"); // RQ1

  // --------------------------------------------------------------
  // Bus and sequence checks
  // --------------------------------------------------------------
  ack_answer_a: assert property (ce_i && req |=> ack) // RQ3
    else $error("no ack");
  ack_single_a: assert property (ce_i && ack |=> !ack) // RQ3
    else $error("ack too long");
  first_key_a: assert property (ce_i && wr_svc && seq == OTWD_IDLE && wb_req_i.dat[7:0] == OTWD_KEY_FIRST // RQ3
    && !overflow |=> seq == OTWD_GOT_FIRST) else $error("first key lost");
  seq_keep_a: assert property (ce_i && !wr_svc && !overflow |=> seq == $past(seq)) // RQ13
    else $error("sequence moved");
  rdat_zero_a: assert property (ce_i && !req |=> wb_rsp_o.dat == 32'h0000_0000) // RQ12
    else $error("stray read data");
  ctrl_write_a: assert property (ce_i && wr_ctrl |=> x2 == $past(wb_req_i.dat[OTWD_CTRL_X2_BIT])) // RQ10
    else $error("mode not written");

  // --------------------------------------------------------------
  // Counter and pulse checks
  // --------------------------------------------------------------
  no_arm_a: assert property (ce_i && !armed && !key_done |=> !armed) // RQ2
    else $error("armed without key");
  ovf_seq_a: assert property (ce_i && overflow |=> seq == OTWD_IDLE && cnt == OTWD_CNT_RESET) // RQ7
    else $error("overflow left state");
  mc_bound_a: assert property (armed |-> mc <= OTWD_MC_12CLK) // RQ4
    else $error("machine cycle too long");
  gap_max_a: assert property (armed |-> gap <= 5'h0b) // RQ4
    else $error("count step missed");
  pulse_end_a: assert property (ce_i && rst_out && pulse == 8'h00 |=> !rst_out) // RQ10
    else $error("pulse too long");
  pulse_idle_a: assert property (!rst_out |-> pulse == 8'h00) // RQ10
    else $error("pulse count left over");
  ce_hold_a: assert property (!ce_i |=> $stable(rst_out) && $stable(pulse) && $stable(seq)) // RQ4
    else $error("moved while stopped");

  arm_c: cover property (ce_i && key_done && !armed);
  service_c: cover property (ce_i && key_done && armed);
  overflow_c: cover property (overflow);
  pulse_end_c: cover property (rst_out ##1 !rst_out);
  twelve_clk_c: cover property (overflow && !x2);
endmodule
`default_nettype wire

//--- tb/otwd_watchdog_tb.sv
// Purpose: Self-checking bench for the one-time enabled watchdog
// Assumes: Classic Wishbone, one access at a time, byte data in dat[7:0]
// Notes: A single overflow in 6-clock mode sets the length of the run
`timescale 1ns/1ns
`default_nettype none
module otwd_watchdog_tb;
  import otwd_pkg::*;
  localparam logic [11:0] svc_adr = 12'(OTWD_SERVICE_ADDR);
  localparam logic [11:0] ctl_adr = 12'(OTWD_CTRL_ADDR);
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  otwd_wb_req_type wb_req_i = '0;
  otwd_wb_rsp_type wb_rsp_o;
  logic rst_pin_o;
  logic rst_pin_oe_o;
  logic armed_o;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  logic [31:0] rd;

  otwd_watchdog dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .armed_o(armed_o));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Holds the request until ack, then releases for at least one idle cycle
  task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] dat);
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, dat}};
    do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
    rd = wb_rsp_o.dat;
    wb_req_i <= '0;
  endtask

  // Hang guard, sized above one full overflow
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 100500) begin
      err_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    check(armed_o, 0, "armed after reset");
    check(rst_pin_oe_o, 0, "pin driven when idle");
    wb(1'b0, svc_adr, 8'h00);
    check(rd, 0, "service read");
    wb(1'b0, 12'h000, 8'h00);
    check(rd, 0, "unmapped read");
    wb(1'b1, ctl_adr, 8'h01);
    wb(1'b1, svc_adr, OTWD_KEY_FIRST);
    wb(1'b1, svc_adr, 8'h55);
    wb(1'b1, svc_adr, OTWD_KEY_SECOND);
    @(posedge clk_i);
    check(armed_o, 0, "broken key pair");
    wb(1'b1, svc_adr, OTWD_KEY_FIRST);
    wb(1'b1, svc_adr, OTWD_KEY_SECOND);
    @(posedge clk_i);
    check(armed_o, 1, "armed by key pair");
    wb(1'b1, ctl_adr, 8'h01);
    wb(1'b0, ctl_adr, 8'h00);
    check(rd, 32'h3, "control readback");
    repeat (1000) @(posedge clk_i);
    // Service late; a missed restart shortens the wait below by about 1000
    wb(1'b1, svc_adr, OTWD_KEY_FIRST);
    wb(1'b1, svc_adr, OTWD_KEY_SECOND);
    ce_i <= 1'b0;
    repeat (50) @(posedge clk_i);
    ce_i <= 1'b1;
    n = 0;
    while (rst_pin_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    check(n >= 16383 * 6 - 6 && n <= 16383 * 6 + 12, 1, "overflow time");
    check(rst_pin_oe_o, 1, "pin driven in pulse");
    check(armed_o, 0, "disarmed by overflow");
    n = 0;
    while (rst_pin_o === 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    check(n, OTWD_PULSE_6CLK, "pulse length");
    check(rst_pin_oe_o, 0, "pin released");
    give_verdict();
  end
endmodule
`default_nettype wire
